// *** rtl/socket_irq_cfg.svh ***
// Offsets, field positions and reset values of the socket interrupt block
`ifndef SOCKET_IRQ_CFG_SVH
`define SOCKET_IRQ_CFG_SVH

`define SIRQ_GEN_CTRL_OFS  12'h803
`define SIRQ_STATUS_OFS    12'h804
`define SIRQ_CTRL_RST      8'h00
`define SIRQ_FLAGS_RST     4'h0
`define SIRQ_PIN_RST       8'h1B
`define SIRQ_PREV_RST      6'h0B

`define SIRQ_CALL_EN_BIT   7
`define SIRQ_RESET_REL_BIT 6
`define SIRQ_KIND_BIT      5
`define SIRQ_PCI_ROUTE_BIT 4

`define SIRQ_DETECT_BIT    3
`define SIRQ_READY_BIT     2
`define SIRQ_LOWBAT_BIT    1
`define SIRQ_FAIL_BIT      0

`define SIRQ_SEL_NONE      4'h0
`define SIRQ_SEL_MGMT      4'h2

`endif

// *** rtl/socket_irq_pkg.sv ***
// Types shared by the socket interrupt block
`default_nettype none
package socket_irq_pkg;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [3:0]  flag_vec_t;
  typedef logic [3:0]  route_sel_t;
  typedef logic [15:0] irq_lines_t;
  typedef logic [11:0] reg_addr_t;
endpackage : socket_irq_pkg
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for the socket pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int         W       = 8,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] stage1_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      stage1_r <= RST_VAL[W-1:0];
      sync_o   <= RST_VAL[W-1:0];
    end else begin
      stage1_r <= async_i;
      sync_o   <= stage1_r;
    end
  end
endmodule : pin_sync
`default_nettype wire

// *** rtl/socket_irq_status_control.sv ***
// Socket interrupt and general control plus status-change flags
`timescale 1ns/10ps
`default_nettype none
`include "socket_irq_cfg.svh"
// How it works
// - Control bit 7 enables call-alert use of the battery-sense pin; resets off.
// - Card reset asserted while control bit 6 is zero; one releases it.
// - Control bit 5 picks card kind: zero memory, one I/O.
// - Routing bit 5 low: bit 4, or bits 3-0 at 0000, sends status change to PCI, else select field.
// - Routing bit 5 high: control bit 4 is ignored.
// - Bits 3-0 route functional interrupts: 0000 none, 0010 system mgmt, others IRQn.
// - A status flag reads zero while its source is disabled.
// - Enabled flags raise the host interrupt; flags show the source.
// - Flags clear on read or by writing one, chosen by clear mode.
// - Status bits 7-4 always read zero.
// - Bit 3 sets on any change of either card-detect line.
// - Memory card: bit 2 sets on READY low-to-high.
// - I/O card: bits 2 and 1 stay zero.
// - Memory card: bit 1 sets on battery-low warning.
// - Bit 0: battery dead for memory, status-changed assertion for I/O.
// - Call-alert mode: bit 0 shows the call-alert input level.
// - Context bits clear on global reset; bus reset too unless PME enabled.
// - Status register at offset 804h, read by host, resets to 00h.
// - Card-detect flags only when detect interrupt enable is set.
module socket_irq_status_control
  import socket_irq_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire reg_addr_t  reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire reg_byte_t  reg_wdata_i,
  output var  reg_byte_t  reg_rdata_o,
  input  wire logic       card_detect_first_n_i,
  input  wire logic       card_detect_second_n_i,
  input  wire logic       card_ready_i,
  input  wire logic       battery_sense_call_pin_i,
  input  wire logic       battery_sense_second_i,
  input  wire logic       card_func_irq_i,
  input  wire logic       global_reset_in_i,
  input  wire logic       bus_reset_in_i,
  input  wire logic       pme_enable_i,
  input  wire logic       status_change_route_ctrl_i,
  input  wire logic       flag_clear_by_write_i,
  input  wire route_sel_t status_change_irq_select_i,
  input  wire logic       detect_irq_enable_i,
  input  wire logic       ready_irq_enable_i,
  input  wire logic       battery_warn_enable_i,
  input  wire logic       battery_fail_enable_i,
  output var  logic       card_reset_o,
  output var  logic       status_change_pci_irq_o,
  output var  irq_lines_t status_change_isa_irq_o,
  output var  logic       system_mgmt_interrupt_o,
  output var  irq_lines_t functional_irq_o
);
  localparam reg_byte_t CTRL_RST = `SIRQ_CTRL_RST;

  logic [7:0] pins_raw;
  logic [7:0] pins_sync;
  logic       det_first_s;
  logic       det_second_s;
  logic       ready_s;
  logic       sense_a_s;
  logic       sense_b_s;
  logic       func_s;
  logic       glob_rst_s;
  logic       bus_rst_s;
  logic       full_rst;
  logic       ctx_rst;

  assign pins_raw = {bus_reset_in_i, global_reset_in_i, card_func_irq_i, battery_sense_second_i,
                     battery_sense_call_pin_i, card_ready_i, card_detect_second_n_i,
                     card_detect_first_n_i};

  pin_sync #(
    .W       (8),
    .RST_VAL (`SIRQ_PIN_RST)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    (pins_raw),
    .sync_o     (pins_sync)
  );

  assign {bus_rst_s, glob_rst_s, func_s, sense_b_s, sense_a_s, ready_s, det_second_s,
          det_first_s} = pins_sync;

  // Context bits survive bus reset while PME is armed
  assign full_rst = reset_i | glob_rst_s | bus_rst_s;
  assign ctx_rst  = reset_i | glob_rst_s | (bus_rst_s & ~pme_enable_i);

  function automatic flag_vec_t status_view(input flag_vec_t f, input flag_vec_t en,
                                            input logic mem, input logic ring_en,
                                            input logic ring_lvl);
    flag_vec_t v;
    v = f & en;
    if (!mem) begin
      v[`SIRQ_READY_BIT]  = 1'b0;
      v[`SIRQ_LOWBAT_BIT] = 1'b0;
    end
    if (ring_en) begin
      v[`SIRQ_FAIL_BIT] = en[`SIRQ_FAIL_BIT] & ring_lvl;
    end
    return v;
  endfunction : status_view

  function automatic irq_lines_t irq_decode(input route_sel_t sel, input logic act);
    irq_lines_t l;
    l = '0;
    if (act && sel != `SIRQ_SEL_NONE && sel != `SIRQ_SEL_MGMT) begin
      l[sel] = 1'b1;
    end
    return l;
  endfunction : irq_decode

  // Control register
  reg_byte_t ctrl_r;
  reg_byte_t ctrl_nxt;
  logic      gen_wr;
  logic      gen_rd;

  assign gen_wr = reg_wr_i && (reg_addr_i == `SIRQ_GEN_CTRL_OFS);
  assign gen_rd = reg_rd_i && (reg_addr_i == `SIRQ_GEN_CTRL_OFS);

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (gen_wr) begin
      ctrl_nxt = reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (full_rst) begin
      ctrl_r[7]   <= CTRL_RST[7];
      ctrl_r[4:0] <= CTRL_RST[4:0];
    end else begin
      ctrl_r[7]   <= ctrl_nxt[7];
      ctrl_r[4:0] <= ctrl_nxt[4:0];
    end
    if (ctx_rst) begin
      ctrl_r[6:5] <= CTRL_RST[6:5];
    end else begin
      ctrl_r[6:5] <= ctrl_nxt[6:5];
    end
  end

  logic mem_card;
  logic ring_en;
  logic ring_lvl;
  assign mem_card = ~ctrl_r[`SIRQ_KIND_BIT];
  assign ring_en  = ctrl_r[`SIRQ_CALL_EN_BIT];
  assign ring_lvl = ~sense_a_s;

  // Previous pin levels for edge detection
  logic [5:0] prev_r;
  logic [5:0] prev_nxt;
  logic       warn_cond;
  logic       dead_cond;

  assign warn_cond = sense_b_s & ~sense_a_s;
  assign dead_cond = ~sense_b_s;

  always_comb begin
    prev_nxt = {dead_cond, warn_cond, sense_a_s, ready_s, det_second_s, det_first_s};
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prev_r <= `SIRQ_PREV_RST;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // Status-change flags
  flag_vec_t flags_r;
  flag_vec_t flags_nxt;
  flag_vec_t set_vec;
  flag_vec_t clr_vec;
  flag_vec_t en_vec;
  flag_vec_t view;
  logic      stat_rd;
  logic      stat_wr;
  logic      pending;

  assign stat_rd = reg_rd_i && (reg_addr_i == `SIRQ_STATUS_OFS);
  assign stat_wr = reg_wr_i && (reg_addr_i == `SIRQ_STATUS_OFS);
  assign en_vec  = {detect_irq_enable_i, ready_irq_enable_i, battery_warn_enable_i,
                    battery_fail_enable_i};

  always_comb begin
    set_vec = '0;
    set_vec[`SIRQ_DETECT_BIT] = detect_irq_enable_i &
                                ((det_first_s ^ prev_r[0]) | (det_second_s ^ prev_r[1]));
    set_vec[`SIRQ_READY_BIT]  = ready_irq_enable_i & mem_card & ready_s & ~prev_r[2];
    set_vec[`SIRQ_LOWBAT_BIT] = battery_warn_enable_i & mem_card & warn_cond &
                                ~prev_r[4];
    set_vec[`SIRQ_FAIL_BIT]   = battery_fail_enable_i & ~ring_en &
                                (mem_card ? (dead_cond & ~prev_r[5]) : (~sense_a_s & prev_r[3]));
    clr_vec = '0;
    if (stat_rd && !flag_clear_by_write_i) begin
      clr_vec = 4'hF;
    end else if (stat_wr && flag_clear_by_write_i) begin
      clr_vec = reg_wdata_i[3:0];
    end
    // Set beats clear so a same-cycle event is kept
    flags_nxt = (flags_r & ~clr_vec) | set_vec;
  end

  always_ff @(posedge core_clk_i) begin
    if (ctx_rst) begin
      flags_r <= `SIRQ_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign view    = status_view(flags_r, en_vec, mem_card, ring_en, ring_lvl);
  assign pending = |view;

  // Routing and registered outputs
  logic       route_pci;
  logic       func_act;
  reg_byte_t  rdata_nxt;
  logic       card_reset_nxt;
  logic       pci_nxt;
  irq_lines_t isa_nxt;
  logic       mgmt_nxt;
  irq_lines_t func_nxt;

  always_comb begin
    if (status_change_route_ctrl_i) begin
      route_pci = (status_change_irq_select_i == `SIRQ_SEL_NONE);
    end else begin
      route_pci = ctrl_r[`SIRQ_PCI_ROUTE_BIT] | (ctrl_r[3:0] == `SIRQ_SEL_NONE);
    end
    func_act       = func_s & ~mem_card;
    rdata_nxt      = '0;
    if (stat_rd) begin
      rdata_nxt = {4'h0, view};
    end else if (gen_rd) begin
      rdata_nxt = ctrl_r;
    end
    card_reset_nxt = ~ctrl_r[`SIRQ_RESET_REL_BIT];
    pci_nxt        = pending & route_pci;
    isa_nxt        = irq_decode(status_change_irq_select_i, pending & ~route_pci);
    func_nxt       = irq_decode(ctrl_r[3:0], func_act);
    mgmt_nxt       = (pending & ~route_pci & (status_change_irq_select_i == `SIRQ_SEL_MGMT)) |
                     (func_act & (ctrl_r[3:0] == `SIRQ_SEL_MGMT));
  end

  // Card held in reset while the socket logic is reset
  always_ff @(posedge core_clk_i) begin
    if (full_rst) begin
      reg_rdata_o             <= 8'h00;
      card_reset_o            <= 1'b1;
      status_change_pci_irq_o <= 1'b0;
      status_change_isa_irq_o <= 16'h0000;
      system_mgmt_interrupt_o <= 1'b0;
      functional_irq_o        <= 16'h0000;
    end else begin
      reg_rdata_o             <= rdata_nxt;
      card_reset_o            <= card_reset_nxt;
      status_change_pci_irq_o <= pci_nxt;
      status_change_isa_irq_o <= isa_nxt;
      system_mgmt_interrupt_o <= mgmt_nxt;
      functional_irq_o        <= func_nxt;
    end
  end

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (full_rst)
    reg_rdata_o[7:4] == 4'h0 || $past(gen_rd))
    else $error("reserved status bits not zero");

  a_release_reset: assert property (@(posedge core_clk_i) disable iff (full_rst)
    gen_wr && reg_wdata_i[6] |-> ##2 !card_reset_o)
    else $error("card reset not released after write");

  a_read_clear: assert property (@(posedge core_clk_i) disable iff (full_rst)
    stat_rd && !flag_clear_by_write_i && set_vec == 4'h0 |=> flags_r == 4'h0)
    else $error("flags not cleared by read");

  a_write_clear: assert property (@(posedge core_clk_i) disable iff (full_rst)
    stat_wr && flag_clear_by_write_i && reg_wdata_i[2] && !set_vec[2] |=> !flags_r[2])
    else $error("ready flag not cleared by write of one");

  a_io_masked: assert property (@(posedge core_clk_i) disable iff (full_rst)
    stat_rd && !mem_card |=> reg_rdata_o[2:1] == 2'b00)
    else $error("io card shows ready or battery flag");

  a_disabled_zero: assert property (@(posedge core_clk_i) disable iff (full_rst)
    stat_rd && !detect_irq_enable_i |=> !reg_rdata_o[3])
    else $error("disabled source reads nonzero");

  a_set_wins: assert property (@(posedge core_clk_i) disable iff (full_rst)
    set_vec[3] |=> flags_r[3])
    else $error("detect change lost");

  a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (full_rst)
    flags_r[0] && clr_vec[0] == 1'b0 |=> flags_r[0])
    else $error("flag dropped without clear");

  a_pci_route: assert property (@(posedge core_clk_i) disable iff (full_rst)
    pending && !status_change_route_ctrl_i && ctrl_r[4] |=> status_change_pci_irq_o)
    else $error("status change not routed to pci");

  a_diag_ignore: assert property (@(posedge core_clk_i) disable iff (full_rst)
    pending && status_change_route_ctrl_i && status_change_irq_select_i != 4'h0
    |=> !status_change_pci_irq_o)
    else $error("control bit 4 not ignored");

  a_ctx_keep: assert property (@(posedge core_clk_i) disable iff (reset_i || glob_rst_s)
    bus_rst_s && pme_enable_i && !gen_wr |=> ctrl_r[6:5] == $past(ctrl_r[6:5]))
    else $error("context bits lost on bus reset");
endmodule : socket_irq_status_control
`default_nettype wire

// *** verification/card_model.sv ***
// Behavioural 16-bit card seen from the socket pins
`timescale 1ns/10ps
`default_nettype none
module card_model (
  input  wire logic card_reset_i,
  output var  logic det_a_n_o,
  output var  logic det_b_n_o,
  output var  logic ready_o,
  output var  logic bat_a_o,
  output var  logic bat_b_o,
  output var  logic fint_o
);
  logic present, rdy, ba, bb, fi;
  initial {present, rdy, ba, bb, fi} = 5'h06;
  // Empty socket: detect lines float to their pull-ups
  assign det_a_n_o = ~present;
  assign det_b_n_o = ~present;
  // A card held in reset cannot report ready
  assign ready_o   = rdy & ~card_reset_i;
  assign bat_a_o   = ba;
  assign bat_b_o   = bb;
  assign fint_o    = fi;
  task set(input logic p, input logic r, input logic a, input logic b, input logic f);
    {present, rdy, ba, bb, fi} = {p, r, a, b, f};
  endtask : set
endmodule : card_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the socket interrupt block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import socket_irq_pkg::*;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, gr = 0, br = 0, pme = 0;
  logic       diag = 1, wmode = 0, en_d = 0, en_r = 0, en_w = 0, en_f = 0;
  reg_addr_t  a = '0;
  reg_byte_t  wd = '0, rdat;
  route_sel_t sel = '0;
  logic       dan, dbn, rdy, ba, bb, fi, crst, pci, mgmt;
  irq_lines_t isa, fio;
  int         n_mismatch = 0, num_checks = 0;
  always #4 clk = ~clk;
  socket_irq_status_control dut (.core_clk_i(clk), .reset_i(rst), .reg_addr_i(a),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .card_detect_first_n_i(dan), .card_detect_second_n_i(dbn), .card_ready_i(rdy),
    .battery_sense_call_pin_i(ba), .battery_sense_second_i(bb), .card_func_irq_i(fi),
    .global_reset_in_i(gr), .bus_reset_in_i(br), .pme_enable_i(pme),
    .status_change_route_ctrl_i(diag), .flag_clear_by_write_i(wmode),
    .status_change_irq_select_i(sel), .detect_irq_enable_i(en_d),
    .ready_irq_enable_i(en_r), .battery_warn_enable_i(en_w),
    .battery_fail_enable_i(en_f), .card_reset_o(crst), .status_change_pci_irq_o(pci),
    .status_change_isa_irq_o(isa), .system_mgmt_interrupt_o(mgmt), .functional_irq_o(fio));
  card_model card (.card_reset_i(crst), .det_a_n_o(dan), .det_b_n_o(dbn), .ready_o(rdy),
    .bat_a_o(ba), .bat_b_o(bb), .fint_o(fi));
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task wr8(input reg_addr_t ad, input reg_byte_t d);
    @(negedge clk);
    a  = ad;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : wr8
  // Read data stands one cycle only, so it is checked at the next falling edge
  task rdc(input reg_addr_t ad, input reg_byte_t e);
    @(negedge clk);
    a  = ad;
    rd = 1;
    @(negedge clk);
    rd = 0;
    chk(16'(rdat), 16'(e));
  endtask : rdc
  task route(input reg_byte_t c, input logic dg, input route_sel_t s, input logic ep,
             input irq_lines_t ei, input logic es);
    diag = dg;
    sel  = s;
    wr8(12'h803, c);
    w(3);
    chk(16'(pci), 16'(ep));
    chk(isa, ei);
    chk(16'(mgmt), 16'(es));
  endtask : route
  // Pin resets pass a synchroniser, so the pulse is held several cycles
  task rpulse(input logic g);
    gr = g;
    br = ~g;
    w(5);
    gr = 0;
    br = 0;
    w(5);
  endtask : rpulse
  initial begin
    w(12);
    rst = 0;
    chk(16'(crst), 16'h1);
    rdc(12'h803, 8'h00);
    rdc(12'h804, 8'h00);
    rdc(12'h800, 8'h00);
    card.set(1, 0, 1, 1, 0);
    w(6);
    rdc(12'h804, 8'h00);
    en_d = 1;
    card.set(0, 0, 1, 1, 0);
    w(6);
    chk(16'(pci), 16'h1);
    rdc(12'h804, 8'h08);
    rdc(12'h804, 8'h00);
    en_d  = 0;
    wmode = 1;
    en_r  = 1;
    wr8(12'h803, 8'h40);
    w(2);
    chk(16'(crst), 16'h0);
    card.set(0, 1, 1, 1, 0);
    w(6);
    card.set(0, 0, 1, 1, 0);
    w(6);
    rdc(12'h804, 8'h04);
    rdc(12'h804, 8'h04);
    wr8(12'h804, 8'h04);
    rdc(12'h804, 8'h00);
    en_w = 1;
    en_f = 1;
    card.set(0, 0, 0, 1, 0);
    w(6);
    rdc(12'h804, 8'h02);
    wr8(12'h804, 8'h02);
    card.set(0, 0, 0, 0, 0);
    w(6);
    rdc(12'h804, 8'h01);
    wr8(12'h804, 8'h01);
    card.set(0, 0, 1, 1, 0);
    en_w = 0;
    wr8(12'h803, 8'hC0);
    card.set(0, 0, 0, 1, 0);
    w(6);
    rdc(12'h804, 8'h01);
    route(8'hC0, 0, 4'h5, 1, 16'h0000, 0);
    route(8'hC5, 0, 4'h5, 0, 16'h0020, 0);
    route(8'hD5, 0, 4'h5, 1, 16'h0000, 0);
    route(8'hD5, 1, 4'h5, 0, 16'h0020, 0);
    route(8'hC0, 1, 4'h2, 0, 16'h0000, 1);
    card.set(0, 0, 1, 1, 0);
    w(6);
    rdc(12'h804, 8'h00);
    sel  = 4'h0;
    en_w = 1;
    wr8(12'h803, 8'h60);
    // Ready rise and warning entry must stay hidden; status-changed fall must latch
    card.set(0, 1, 0, 1, 1);
    w(6);
    rdc(12'h804, 8'h01);
    for (int n = 1; n < 16; n++) begin
      wr8(12'h803, 8'h60 | 8'(n));
      w(4);
      chk(fio, (n == 2) ? 16'h0000 : 16'h0001 << n);
      chk(16'(mgmt), 16'(n == 2));
    end
    pme = 1;
    rpulse(0);
    rdc(12'h803, 8'h60);
    rdc(12'h804, 8'h01);
    pme = 0;
    rpulse(0);
    rdc(12'h803, 8'h00);
    chk(16'(crst), 16'h1);
    rdc(12'h804, 8'h00);
    wr8(12'h803, 8'h60);
    pme = 1;
    rpulse(1);
    rdc(12'h803, 8'h00);
    wrap_up;
  end
  // Bound on the whole run in case the main sequence never reaches wrap_up
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
